//--- dcd_ctrl.sv
// Purpose: host sequencer driving a four-bank ddr2 command bus
// Assumes: requests held until accepted; inputs synchronous to CLK_I
// Notes:   illegal requests are refused with a one-cycle error pulse
`timescale 1ns/100ps
module dcd_ctrl (
    // clock and reset
    input  wire logic             CLK_I,
    input  wire logic             ARST_N_I,
    // user request
    input  wire logic             REQ_VALID_I,
    input  dcd_pkg::dcd_req_t     REQ_I,
    input  wire logic             ODT_EN_I,
    input  wire logic             WR_MASK_I,
    output logic                  REQ_READY_O,
    output logic                  REQ_ERR_O,
    // memory pins
    output dcd_pkg::dcd_pins_t    PINS_O,
    output logic                  DM_O,
    // status
    output logic [3:0]            BANK_OPEN_O,
    output logic                  POWER_DOWN_O,
    output logic                  SELF_REF_O
);
    typedef enum logic [1:0] {ST_RUN, ST_PD, ST_SR} dcd_st_t;

    dcd_st_t            st_q;
    logic [3:0]         open_q;
    logic [7:0]         busy_q;
    logic [7:0]         cke_q;
    logic [7:0]         xsnr_q;
    logic [7:0]         xsrd_q;
    logic [1:0]         beat_q;
    logic               wrbeat_q;
    logic               ocd_q;
    dcd_pkg::dcd_pins_t pins_q;
    logic               dm_q;
    logic               take;
    logic               legal;
    dcd_pkg::dcd_cmd_t  c;

    // pins for one encoded command with cs low
    function automatic dcd_pkg::dcd_pins_t enc(
        input logic [2:0]                  rcw,
        input logic [1:0]                  ba,
        input logic [dcd_pkg::ROW_W-1:0]   a,
        input logic                        cke,
        input logic                        odt
    );
        dcd_pkg::dcd_pins_t p;
        p.cke   = cke;
        p.cs_n  = 1'b0;
        p.ras_n = rcw[2];
        p.cas_n = rcw[1];
        p.we_n  = rcw[0];
        p.ba    = ba;
        p.a     = a;
        p.odt   = odt;
        return p;
    endfunction : enc

    assign c = REQ_I.cmd;

    always_comb begin
        legal = 1'b0;
        case (st_q)
            ST_RUN: begin
                case (c)
                    dcd_pkg::CMD_NOP, dcd_pkg::CMD_DESEL:
                        legal = 1'b1;
                    dcd_pkg::CMD_MRS:
                        legal = (open_q == 4'h0);
                    dcd_pkg::CMD_REF:
                        legal = (open_q == 4'h0);
                    dcd_pkg::CMD_ACT:
                        legal = !open_q[REQ_I.bank];
                    dcd_pkg::CMD_RD:
                        legal = open_q[REQ_I.bank] && (xsrd_q == 8'h00);
                    dcd_pkg::CMD_WR:
                        legal = open_q[REQ_I.bank] && !(REQ_I.auto_pre &&
                                dcd_pkg::CLK_PS < dcd_pkg::WRAP_MIN_PS);
                    dcd_pkg::CMD_PRE:
                        legal = 1'b1;
                    dcd_pkg::CMD_PD_ENTER:
                        legal = !ocd_q;
                    dcd_pkg::CMD_SR_ENTER:
                        legal = (open_q == 4'h0) && !ocd_q;
                    default:
                        legal = 1'b0;
                endcase
            end
            ST_PD:
                legal = (c == dcd_pkg::CMD_PD_EXIT);
            ST_SR:
                legal = (c == dcd_pkg::CMD_SR_EXIT);
            default:
                legal = 1'b0;
        endcase
    end

    // stall rules
    // no command may ride on the cke rise that follows reset
    assign REQ_READY_O = (busy_q == 8'h00) && (beat_q == 2'h0) &&
                         (xsnr_q == 8'h00) && (cke_q == 8'h00) &&
                         (pins_q.cke || st_q != ST_RUN);
    assign take = REQ_VALID_I && REQ_READY_O && legal;

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            REQ_ERR_O <= 1'b0;
        end else begin
            REQ_ERR_O <= REQ_VALID_I && REQ_READY_O && !legal;
        end
    end

    // pin drive
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pins_q <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                        we_n: 1'b1, ba: 2'h0, a: '0, odt: 1'b0};
        end else begin
            // default nop keeps cke, odt defined in power-down
            pins_q <= enc(dcd_pkg::ENC_NOP, 2'h0, '0, pins_q.cke,
                          ODT_EN_I && st_q != ST_SR);
            if (st_q == ST_RUN && !take) begin
                pins_q.cke <= 1'b1;
            end
            if (take) begin
                case (c)
                    dcd_pkg::CMD_MRS:
                        pins_q <= enc(dcd_pkg::ENC_MRS, REQ_I.bank,
                                      REQ_I.addr, 1'b1, ODT_EN_I);
                    dcd_pkg::CMD_REF:
                        pins_q <= enc(dcd_pkg::ENC_REF, 2'h0, '0, 1'b1,
                                      ODT_EN_I);
                    dcd_pkg::CMD_ACT:
                        pins_q <= enc(dcd_pkg::ENC_ACT, REQ_I.bank,
                                      REQ_I.addr, 1'b1, ODT_EN_I);
                    dcd_pkg::CMD_RD, dcd_pkg::CMD_WR: begin
                        pins_q <= enc(c == dcd_pkg::CMD_RD ? dcd_pkg::ENC_RD
                                      : dcd_pkg::ENC_WR, REQ_I.bank,
                                      REQ_I.addr, 1'b1, ODT_EN_I);
                        pins_q.a[dcd_pkg::A10_POS] <= REQ_I.auto_pre;
                    end
                    dcd_pkg::CMD_PRE: begin
                        pins_q <= enc(dcd_pkg::ENC_PRE, REQ_I.bank, '0,
                                      1'b1, ODT_EN_I);
                        pins_q.a[dcd_pkg::A10_POS] <= REQ_I.all_banks;
                    end
                    // cke falls with nop, odt held
                    dcd_pkg::CMD_PD_ENTER:
                        pins_q <= enc(dcd_pkg::ENC_NOP, 2'h0, '0, 1'b0,
                                      ODT_EN_I);
                    dcd_pkg::CMD_SR_ENTER:
                        pins_q <= enc(dcd_pkg::ENC_REF, 2'h0, '0, 1'b0,
                                      1'b0);
                    dcd_pkg::CMD_PD_EXIT, dcd_pkg::CMD_SR_EXIT:
                        pins_q <= enc(dcd_pkg::ENC_NOP, 2'h0, '0, 1'b1,
                                      1'b0);
                    dcd_pkg::CMD_DESEL:
                        pins_q.cs_n <= 1'b1;
                    default:
                        pins_q <= pins_q;
                endcase
            end
        end
    end

    // low-power state
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q <= ST_RUN;
        end else if (take) begin
            case (c)
                dcd_pkg::CMD_PD_ENTER: st_q <= ST_PD;
                dcd_pkg::CMD_SR_ENTER: st_q <= ST_SR;
                dcd_pkg::CMD_PD_EXIT,
                dcd_pkg::CMD_SR_EXIT:  st_q <= ST_RUN;
                default:               st_q <= st_q;
            endcase
        end
    end

    // bank tracking; auto precharge closes the bank in the cycle the read or write is taken
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            open_q <= 4'h0;
        end else if (take) begin
            if (c == dcd_pkg::CMD_ACT) begin
                open_q[REQ_I.bank] <= 1'b1;
            end else if (c == dcd_pkg::CMD_PRE) begin
                if (REQ_I.all_banks) begin
                    open_q <= 4'h0;
                end else begin
                    open_q[REQ_I.bank] <= 1'b0;
                end
            end else if ((c == dcd_pkg::CMD_RD || c == dcd_pkg::CMD_WR) &&
                         REQ_I.auto_pre) begin
                open_q[REQ_I.bank] <= 1'b0;
            end
        end
    end

    // operation timers; ocd mode latched from mrs to emr1
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            busy_q <= 8'h00;
            ocd_q  <= 1'b0;
        end else if (take) begin
            case (c)
                dcd_pkg::CMD_MRS: busy_q <= 8'(dcd_pkg::MRD_CK);
                dcd_pkg::CMD_REF: busy_q <= 8'(dcd_pkg::RFC_CK);
                dcd_pkg::CMD_PRE: busy_q <= 8'(dcd_pkg::RP_CK);
                // one clock on entry and exit
                dcd_pkg::CMD_PD_ENTER,
                dcd_pkg::CMD_PD_EXIT: busy_q <= 8'h01;
                default:          busy_q <= 8'h00;
            endcase
            if (c == dcd_pkg::CMD_MRS && REQ_I.bank == dcd_pkg::BA_EMR1) begin
                ocd_q <= REQ_I.ocd_mode;
            end
        end else if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            beat_q   <= 2'h0;
            wrbeat_q <= 1'b0;
            dm_q     <= 1'b0;
        end else begin
            if (take && (c == dcd_pkg::CMD_RD || c == dcd_pkg::CMD_WR)) begin
                beat_q   <= 2'(dcd_pkg::T_BURST_CK);
                wrbeat_q <= (c == dcd_pkg::CMD_WR);
            end else if (beat_q != 2'h0) begin
                beat_q <= beat_q - 2'h1;
            end
            dm_q <= wrbeat_q && (beat_q != 2'h0) && WR_MASK_I;
        end
    end

    // cke pulse and self refresh exit timers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cke_q  <= 8'h00;
            xsnr_q <= 8'h00;
            xsrd_q <= 8'h00;
        end else begin
            if (take && (c == dcd_pkg::CMD_PD_ENTER ||
                         c == dcd_pkg::CMD_PD_EXIT ||
                         c == dcd_pkg::CMD_SR_ENTER ||
                         c == dcd_pkg::CMD_SR_EXIT)) begin
                cke_q <= 8'(dcd_pkg::T_CKE_CK);
            end else if (st_q == ST_RUN && !pins_q.cke) begin
                // cke rises after reset; that high time counts too
                cke_q <= 8'(dcd_pkg::T_CKE_CK);
            end else if (cke_q != 8'h00) begin
                cke_q <= cke_q - 8'h01;
            end
            if (take && c == dcd_pkg::CMD_SR_EXIT) begin
                xsnr_q <= 8'(dcd_pkg::XSNR_CK);
                xsrd_q <= 8'(dcd_pkg::T_XSRD_CK);
            end else begin
                if (xsnr_q != 8'h00) xsnr_q <= xsnr_q - 8'h01;
                if (xsrd_q != 8'h00) xsrd_q <= xsrd_q - 8'h01;
            end
        end
    end

    assign PINS_O       = pins_q;
    assign DM_O         = dm_q;
    assign BANK_OPEN_O  = open_q;
    assign POWER_DOWN_O = (st_q == ST_PD);
    assign SELF_REF_O   = (st_q == ST_SR);
endmodule : dcd_ctrl

//--- dcd_pkg.sv
// Purpose: constants and types for the host-side command sequencer
// Assumes: 50 MHz clock, four banks, x16 memory, burst length four
// Notes:   timing counts are cycles at the 20 ns clock
// Notes on behaviour
// - bank address picks mode or extended mode register on mrs.
// - mode register commands only with every bank precharged.
// - power-down does no refresh; exit in time for refresh interval.
// - power-down entry and exit each take one extra clock.
// - never drive a combination the command table does not list.
// - after self refresh exit only nop until non-read exit time passes.
// - after self refresh exit hold reads until read exit time passes.
// - self refresh entered only with every bank idle.
// - no low-power entry while rd, wr, mrs or precharge in progress.
// - each cke level held at least the minimum cke pulse time.
// - cke stays high during off-chip driver calibration.
// - termination input driven to a defined level in power-down.
// - data mask applies to write beats only, one per beat.
// - no write with auto precharge when clock period below 1.875 ns.
// - ba0 low, ba1 high selects second extended mode register.
// - both bank address lines high select third extended mode register.
package dcd_pkg;
    localparam int NBANK       = 4;
    localparam int ROW_W       = 13;
    localparam int CLK_PS      = 20000;
    localparam int WRAP_MIN_PS = 1875;
    localparam int A10_POS     = 10;
    // command timing figures, in ns; xsrd, cke and burst figures in clock cycles
    localparam int T_MRD_NS    = 30;
    localparam int T_RP_NS     = 15;
    localparam int T_RFC_NS    = 128;
    localparam int T_XSNR_NS   = 138;
    localparam int T_XSRD_CK   = 200;
    localparam int T_CKE_CK    = 3;
    localparam int T_BURST_CK  = 2;
    localparam int CLK_NS      = 20;
    localparam int MRD_CK  = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CK   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RFC_CK  = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
    localparam int XSNR_CK = (T_XSNR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] RESET_WAIT = 8'h00;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_MRS, CMD_REF, CMD_ACT, CMD_RD, CMD_WR,
        CMD_PRE, CMD_PD_ENTER, CMD_PD_EXIT, CMD_SR_ENTER, CMD_SR_EXIT,
        CMD_DESEL
    } dcd_cmd_t;

    // request from the user side
    typedef struct packed {
        dcd_cmd_t          cmd;
        logic [1:0]        bank;
        logic [ROW_W-1:0]  addr;
        logic              auto_pre;
        logic              all_banks;
        logic              ocd_mode;
    } dcd_req_t;

    // memory pin bundle, all driven from flip-flops
    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [1:0]        ba;
        logic [ROW_W-1:0]  a;
        logic              odt;
    } dcd_pins_t;

    // ras, cas, we encoding for cs low
    localparam logic [2:0] ENC_MRS = 3'h0;
    localparam logic [2:0] ENC_REF = 3'h1;
    localparam logic [2:0] ENC_PRE = 3'h2;
    localparam logic [2:0] ENC_ACT = 3'h3;
    localparam logic [2:0] ENC_WR  = 3'h4;
    localparam logic [2:0] ENC_RD  = 3'h5;
    localparam logic [2:0] ENC_NOP = 3'h7;
    localparam logic [1:0] BA_MR   = 2'h0;
    localparam logic [1:0] BA_EMR1 = 2'h1;
    localparam logic [1:0] BA_EMR2 = 2'h2;
    localparam logic [1:0] BA_EMR3 = 2'h3;
endpackage : dcd_pkg

//--- dcd_checker.sv
// Purpose: pin-level checks on the host command sequencer
// Assumes: one clock domain, async active-low reset
// Notes:   watches top-level ports only
`timescale 1ns/100ps
module dcd_checker (
    // clock and reset
    input wire logic          CLK_I,
    input wire logic          ARST_N_I,
    // observed ports
    input wire logic          REQ_VALID_I,
    input wire logic          REQ_ERR_O,
    input dcd_pkg::dcd_pins_t PINS_O,
    input wire logic [3:0]    BANK_OPEN_O,
    input wire logic          SELF_REF_O
);
    wire [2:0] rcw  = {PINS_O.ras_n, PINS_O.cas_n, PINS_O.we_n};
    wire       sel  = !PINS_O.cs_n;
    wire       idle = PINS_O.cs_n || rcw == 3'h7;
    wire       rdwr = sel && (rcw == dcd_pkg::ENC_RD || rcw == dcd_pkg::ENC_WR);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    legal_code_a: assert property (sel |-> rcw != 3'h6)
        else $error("undefined command code on pins");
    mrs_idle_a: assert property (sel && rcw == dcd_pkg::ENC_MRS
        |-> BANK_OPEN_O == 4'h0) else $error("mode write with bank open");
    sr_idle_a: assert property ($fell(PINS_O.cke) && sel
        && rcw == dcd_pkg::ENC_REF |-> BANK_OPEN_O == 4'h0)
        else $error("self refresh with bank open");
    pd_entry_a: assert property ($fell(PINS_O.cke)
        |-> idle || (sel && rcw == dcd_pkg::ENC_REF))
        else $error("cke fell with a command");
    cke_high_a: assert property ($rose(PINS_O.cke) |-> PINS_O.cke[*3])
        else $error("cke high pulse too short");
    cke_low_a: assert property ($fell(PINS_O.cke) |-> !PINS_O.cke[*3])
        else $error("cke low pulse too short");
    xsnr_idle_a: assert property ($rose(PINS_O.cke) && $past(SELF_REF_O)
        |-> idle[*7]) else $error("command too soon after self refresh");
    pre_all_a: assert property (sel && rcw == dcd_pkg::ENC_PRE
        && PINS_O.a[10] |-> ##[0:1] BANK_OPEN_O == 4'h0)
        else $error("precharge all left a bank open");
    burst_run_a: assert property (rdwr |=> idle[*2])
        else $error("burst interrupted");
    err_cause_a: assert property (REQ_ERR_O |-> $past(REQ_VALID_I))
        else $error("error pulse without request");
    odt_sr_a: assert property (SELF_REF_O && $past(SELF_REF_O)
        |-> !PINS_O.odt) else $error("termination on in self refresh");
endmodule : dcd_checker

bind dcd_ctrl dcd_checker dcd_checker_inst (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_ERR_O(REQ_ERR_O), .PINS_O(PINS_O),
    .BANK_OPEN_O(BANK_OPEN_O), .SELF_REF_O(SELF_REF_O));

//--- dcd_dram_model.sv
// Purpose: behavioural four-bank memory decoding the command pins
// Assumes: pins change just after the rising edge
// Notes:   counts commands it would reject instead of storing data
`timescale 1ns/100ps
module dcd_dram_model (
    // clock and reset
    input wire logic          clk_i,
    input wire logic          arst_n_i,
    // memory pins
    input dcd_pkg::dcd_pins_t pins_i,
    input wire logic          dm_i,
    // observed state
    output logic [3:0]        open_o,
    output logic [1:0]        mr_o,
    output logic              pd_o,
    output logic              sr_o,
    output int                bad_o
);
    logic      ck_q;
    wire [2:0] rcw = {pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
    wire       sel = !pins_i.cs_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ck_q   <= 1'b0;
            open_o <= 4'h0;
            mr_o   <= 2'h0;
            pd_o   <= 1'b0;
            sr_o   <= 1'b0;
            bad_o  <= 0;
        end else begin
            ck_q <= pins_i.cke;
            // two cke samples, odt and dm ignored
            if (ck_q && pins_i.cke && sel) begin
                case (rcw)
                    dcd_pkg::ENC_MRS: begin
                        mr_o <= pins_i.ba;
                        if (open_o != 4'h0) bad_o <= bad_o + 1;
                    end
                    dcd_pkg::ENC_ACT: open_o[pins_i.ba] <= 1'b1;
                    // a10 closes bank on the read or write command itself
                    dcd_pkg::ENC_RD, dcd_pkg::ENC_WR: begin
                        if (!open_o[pins_i.ba]) bad_o <= bad_o + 1;
                        if (pins_i.a[10]) open_o[pins_i.ba] <= 1'b0;
                    end
                    dcd_pkg::ENC_PRE: begin
                        if (pins_i.a[10]) open_o <= 4'h0;
                        else open_o[pins_i.ba] <= 1'b0;
                    end
                    dcd_pkg::ENC_REF, 3'h7: ;
                    default: bad_o <= bad_o + 1;
                endcase
            end
            if (ck_q && !pins_i.cke) begin
                sr_o <= sel && rcw == dcd_pkg::ENC_REF;
                pd_o <= !(sel && rcw == dcd_pkg::ENC_REF);
            end
            // exit on cke rise alone, clock not needed by a real part
            if (!ck_q && pins_i.cke) begin
                sr_o <= 1'b0;
                pd_o <= 1'b0;
            end
        end
    end
endmodule : dcd_dram_model

//--- tb_top.sv
// Purpose: directed bench for the host command sequencer
// Assumes: request held until ready, released after the taking edge
// Notes:   expectations come from the command table, not the design
`timescale 1ns/100ps
module tb_top;
    logic               CLK_I = 1'b0;
    logic               ARST_N_I = 1'b0;
    logic               REQ_VALID_I = 1'b0;
    dcd_pkg::dcd_req_t  REQ_I = '0;
    logic               ODT_EN_I = 1'b0;
    logic               WR_MASK_I = 1'b0;
    logic               REQ_READY_O, REQ_ERR_O, DM_O, POWER_DOWN_O, SELF_REF_O;
    dcd_pkg::dcd_pins_t PINS_O;
    logic [3:0]         BANK_OPEN_O, m_open;
    logic [1:0]         m_mr;
    logic               m_pd, m_sr, e, ocd = 1'b0;
    int                 m_bad, k, fail_count = 0, comparisons = 0;
    always #10 CLK_I = ~CLK_I;
    dcd_ctrl dcd_ctrl_inst (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
        .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .ODT_EN_I(ODT_EN_I),
        .WR_MASK_I(WR_MASK_I), .REQ_READY_O(REQ_READY_O),
        .REQ_ERR_O(REQ_ERR_O), .PINS_O(PINS_O), .DM_O(DM_O),
        .BANK_OPEN_O(BANK_OPEN_O), .POWER_DOWN_O(POWER_DOWN_O),
        .SELF_REF_O(SELF_REF_O));
    dcd_dram_model dcd_dram_model_inst (.clk_i(CLK_I), .arst_n_i(ARST_N_I),
        .pins_i(PINS_O), .dm_i(DM_O), .open_o(m_open), .mr_o(m_mr),
        .pd_o(m_pd), .sr_o(m_sr), .bad_o(m_bad));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic issue(input dcd_pkg::dcd_cmd_t c, input logic [1:0] b,
                         input logic ap, output logic err);
        int n;
        n = 0;
        @(posedge CLK_I) #1;
        REQ_I = '{c, b, {2'h0, ap, 10'h0}, ap, ap, ocd};
        REQ_VALID_I = 1'b1;
        while (REQ_READY_O !== 1'b1 && n < 400) begin
            @(posedge CLK_I) #1;
            n++;
        end
        chk(n < 400, 1'b1);
        @(posedge CLK_I) #1;
        REQ_VALID_I = 1'b0;
        err = REQ_ERR_O;
    endtask : issue
    task automatic t_mrs;
        for (int b = 0; b < 4; b++) begin
            issue(dcd_pkg::CMD_MRS, b[1:0], 1'b0, e);
            chk(e, 1'b0);
            @(posedge CLK_I) #1;
            chk(m_mr, b[1:0]);
        end
    endtask : t_mrs
    task automatic t_burst;
        issue(dcd_pkg::CMD_ACT, 2'h1, 1'b0, e);
        @(posedge CLK_I) #1;
        chk({BANK_OPEN_O, m_open}, 8'h22);
        WR_MASK_I = 1'b1;
        for (int w = 0; w < 2; w++) begin
            issue(w ? dcd_pkg::CMD_WR : dcd_pkg::CMD_RD, 2'h1, w[0], e);
            k = 0;
            repeat (4) begin
                k += DM_O;
                @(posedge CLK_I) #1;
            end
            chk(k, w * 2);
        end
        WR_MASK_I = 1'b0;
        repeat (4) @(posedge CLK_I) #1;
        chk({BANK_OPEN_O, m_open}, 8'h00);
    endtask : t_burst
    task automatic t_illegal;
        issue(dcd_pkg::CMD_ACT, 2'h2, 1'b0, e);
        issue(dcd_pkg::CMD_MRS, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_RD, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_ACT, 2'h2, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_SR_ENTER, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_PRE, 2'h0, 1'b1, e);
        @(posedge CLK_I) #1;
        chk({BANK_OPEN_O, m_open}, 8'h00);
    endtask : t_illegal
    task automatic t_ocd;
        ocd = 1'b1;
        issue(dcd_pkg::CMD_MRS, 2'h1, 1'b0, e);
        ocd = 1'b0;
        issue(dcd_pkg::CMD_PD_ENTER, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_MRS, 2'h1, 1'b0, e);
        chk(e, 1'b0);
    endtask : t_ocd
    task automatic t_pd;
        ODT_EN_I = 1'b1;
        issue(dcd_pkg::CMD_PD_ENTER, 2'h0, 1'b0, e);
        chk(PINS_O.cke, 1'b0);
        @(posedge CLK_I) #1;
        chk({POWER_DOWN_O, m_pd}, 2'h3);
        issue(dcd_pkg::CMD_ACT, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        issue(dcd_pkg::CMD_PD_EXIT, 2'h0, 1'b0, e);
        chk(PINS_O.cke, 1'b1);
        @(posedge CLK_I) #1;
        chk({POWER_DOWN_O, m_pd}, 2'h0);
    endtask : t_pd
    task automatic t_sr;
        issue(dcd_pkg::CMD_SR_ENTER, 2'h0, 1'b0, e);
        @(posedge CLK_I) #1;
        chk({SELF_REF_O, m_sr, PINS_O.odt}, 3'h6);
        issue(dcd_pkg::CMD_SR_EXIT, 2'h0, 1'b0, e);
        chk(e, 1'b0);
        chk(REQ_READY_O, 1'b0);
        issue(dcd_pkg::CMD_ACT, 2'h0, 1'b0, e);
        issue(dcd_pkg::CMD_RD, 2'h0, 1'b0, e);
        chk(e, 1'b1);
        repeat (200) @(posedge CLK_I);
        issue(dcd_pkg::CMD_RD, 2'h0, 1'b1, e);
        chk(e, 1'b0);
        ODT_EN_I = 1'b0;
    endtask : t_sr
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge CLK_I);
        chk({PINS_O.cke, PINS_O.cs_n}, 2'h1);
        #1 ARST_N_I = 1'b1;
        @(posedge CLK_I) #1;
        chk({PINS_O.cke, PINS_O.cs_n, PINS_O.ras_n}, 3'h5);
        t_mrs();
        t_burst();
        t_illegal();
        t_ocd();
        t_pd();
        t_sr();
        repeat (4) @(posedge CLK_I) #1;
        chk(m_bad, 0);
        report_and_stop();
    end
    // long enough for roughly 5000 cycles of traffic
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
endmodule : tb_top
